//--- hw/deser_ctl_pkg.sv
// Purpose: shared constants and types of the receiver control block
// Assumes: APB with 32-bit data, 20 MHz system clock
// Notes:   register map, field layouts, modes and states
package deser_ctl_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int          APB_AW         = 8;
  localparam logic [7:0]  ADDR_OVERRIDE  = 8'h00;
  localparam logic [7:0]  ADDR_CONFIG    = 8'h04;
  localparam logic [7:0]  ADDR_STATUS    = 8'h08;
  localparam logic [7:0]  OVERRIDE_KEY   = 8'h01;
  localparam logic [7:0]  OVERRIDE_RST   = 8'h00;

  // ---------------------------------------------------------------
  // modes
  // ---------------------------------------------------------------
  localparam logic [1:0]  MODE_FILT_OFF  = 2'h0;
  localparam logic [1:0]  MODE_FILT_ON   = 2'h1;
  localparam logic [1:0]  MODE_GEN2      = 2'h2;
  localparam logic [1:0]  MODE_GEN1      = 2'h3;

  // ---------------------------------------------------------------
  // timing and sizes
  // ---------------------------------------------------------------
  localparam int          MIN_PULSE      = 3;
  localparam int          LOCK_PIXELS    = 16;
  localparam int          STOP_CYCLES    = 64;
  localparam int          OSC_HALF       = 4;
  localparam int          LANES          = 4;
  localparam int          LANE_BITS      = 7;

  typedef logic [LANES-1:0][LANE_BITS-1:0] lanes_t;

  // config register, bit 0 upward: mode, map, eq, oss, osc
  typedef struct packed {
    logic       osc_out;
    logic       oss;
    logic       equalizer;
    logic       map_msb;
    logic [1:0] mode;
  } cfg_s;
  localparam cfg_s CFG_RST = '0;

  // strap pins
  typedef struct packed {
    logic       out_en;
    logic       oss;
    logic       equalizer;
    logic       map_msb;
    logic [1:0] mode;
  } straps_s;

  // recovered pixel word with its embedded clock bits
  typedef struct packed {
    logic       c1;
    logic       c0;
    logic       data_en;
    logic       hsync;
    logic       vsync;
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } pixel_s;

  // status register, bit 0 upward
  typedef struct packed {
    logic       override;
    logic       equalizer;
    logic [1:0] mode;
    logic       filter_on;
    logic       sleep;
    logic       lock;
  } status_s;

  typedef enum logic [1:0] {ST_OFF, ST_ACQUIRE, ST_LOCKED, ST_SLEEP} state_e;

endpackage

//--- hw/ctl_glitch_filter.sv
// Purpose: glitch filter for one video control signal
// Assumes: step_i is a one-cycle pixel enable
// Notes:   a new level must persist for MIN_PULSE pixels
`timescale 1ns/1ns
module ctl_glitch_filter #(
  parameter int MIN_PULSE = deser_ctl_pkg::MIN_PULSE
) (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_b_i,
  // control
  input  wire logic step_i,
  input  wire logic bypass_i,
  // signal
  input  wire logic level_i,
  output logic      level_o
);

  logic [3:0] run_reg;

  // ---------------------------------------------------------------
  // qualify changes
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_reg <= 4'h0;
      level_o <= 1'b0;
    end else if (step_i) begin
      if (bypass_i || level_i == level_o) begin
        run_reg <= 4'h0;
        level_o <= level_i;
      end else if (run_reg + 4'h1 >= 4'(MIN_PULSE)) begin
        run_reg <= 4'h0;
        level_o <= level_i;
      end else begin
        run_reg <= run_reg + 4'h1;
      end
    end
  end

endmodule

//--- hw/deser_mode_output_control.sv
// Purpose: mode, filter, mapping, lock and output-state control
// Assumes: link clock and pins are asynchronous to clk_sys_i
// Notes:   registers on APB; output enables are active low
`timescale 1ns/1ns

module deser_mode_output_control #(
  parameter int LOCK_PIXELS = deser_ctl_pkg::LOCK_PIXELS,
  parameter int STOP_CYCLES = deser_ctl_pkg::STOP_CYCLES,
  parameter int OSC_HALF    = deser_ctl_pkg::OSC_HALF
) (
  // clock and reset
  input  wire logic                               clk_sys_i,
  input  wire logic                               rst_b_i,
  // apb slave
  input  wire logic                               psel_i,
  input  wire logic                               penable_i,
  input  wire logic                               pwrite_i,
  input  wire logic [deser_ctl_pkg::APB_AW-1:0]   paddr_i,
  input  wire logic [31:0]                        pwdata_i,
  output logic [31:0]                             prdata_o,
  output logic                                    pready_o,
  output logic                                    pslverr_o,
  // straps and control pins
  input  wire deser_ctl_pkg::straps_s             straps_i,
  input  wire logic                               power_down_n_i,
  // recovered link
  input  wire logic                               link_clk_i,
  input  wire deser_ctl_pkg::pixel_s              pixel_i,
  // display outputs
  output deser_ctl_pkg::lanes_t                   lane_out_o,
  output logic                                    lane_out_oe_n_o,
  output logic                                    clock_out_o,
  output logic                                    clock_out_oe_n_o,
  output logic                                    pass_o,
  output logic                                    pass_oe_n_o,
  // status
  output logic                                    lock_o,
  output logic                                    low_power_o,
  output logic                                    equalizer_on_o
);

  deser_ctl_pkg::straps_s strap_meta_reg;
  deser_ctl_pkg::straps_s strap_reg;
  deser_ctl_pkg::pixel_s  pix_meta_reg;
  deser_ctl_pkg::pixel_s  pix_sync_reg;
  deser_ctl_pkg::pixel_s  pix_reg;
  deser_ctl_pkg::cfg_s    cfg_reg;
  deser_ctl_pkg::cfg_s    eff;
  deser_ctl_pkg::status_s status;
  deser_ctl_pkg::state_e  state_reg;
  deser_ctl_pkg::lanes_t  lane_reg;
  logic [7:0]             override_reg;
  logic                   pwr_meta_reg;
  logic                   pwr_reg;
  logic [2:0]             lclk_reg;
  logic                   step;
  logic                   override;
  logic                   filter_on;
  logic                   frame_ok;
  logic                   stopped;
  logic [7:0]             idle_reg;
  logic [7:0]             lock_cnt_reg;
  logic                   data_en_f;
  logic                   hsync_f;
  logic                   vsync_f;
  logic [3:0]             osc_cnt_reg;
  logic                   osc_reg;
  logic                   src_rec;
  logic                   src_reg;
  logic                   hold_reg;
  logic                   clk_lvl_reg;
  logic                   new_lvl;
  logic                   locked;
  logic                   drive_low;
  logic                   clk_drv;
  logic                   lane_drv;
  logic                   pass_drv;
  logic                   mapped;
  logic [7:0]             map_r;
  logic [7:0]             map_g;
  logic [7:0]             map_b;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      strap_meta_reg <= '0;
      strap_reg      <= '0;
      pwr_meta_reg   <= 1'b0;
      pwr_reg        <= 1'b0;
      lclk_reg       <= 3'h0;
      pix_meta_reg   <= '0;
      pix_sync_reg   <= '0;
    end else begin
      strap_meta_reg <= straps_i;
      strap_reg      <= strap_meta_reg;
      pwr_meta_reg   <= power_down_n_i;
      pwr_reg        <= pwr_meta_reg;
      lclk_reg       <= {lclk_reg[1:0], link_clk_i};
      pix_meta_reg   <= pixel_i;
      pix_sync_reg   <= pix_meta_reg;
    end
  end

  assign step     = lclk_reg[1] & ~lclk_reg[2];
  assign frame_ok = pix_reg.c1 & ~pix_reg.c0;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pix_reg <= '0;
    end else if (step) begin
      pix_reg <= pix_sync_reg;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      override_reg <= deser_ctl_pkg::OVERRIDE_RST;
      cfg_reg      <= deser_ctl_pkg::CFG_RST;
    end else if (!pwr_reg) begin
      override_reg <= deser_ctl_pkg::OVERRIDE_RST;
      cfg_reg      <= deser_ctl_pkg::CFG_RST;
    end else if (psel_i && penable_i && pwrite_i) begin
      if (paddr_i == deser_ctl_pkg::ADDR_OVERRIDE) begin
        override_reg <= pwdata_i[7:0];
      end
      if (paddr_i == deser_ctl_pkg::ADDR_CONFIG) begin
        cfg_reg <= pwdata_i[$bits(deser_ctl_pkg::cfg_s)-1:0];
      end
    end
  end

  assign override = (override_reg == deser_ctl_pkg::OVERRIDE_KEY);

  always_comb begin
    eff = cfg_reg;
    if (!override) begin
      eff.mode    = strap_reg.mode;
      eff.map_msb = strap_reg.map_msb;
      eff.equalizer = strap_reg.equalizer;
      eff.oss     = strap_reg.oss;
    end
  end

  assign filter_on = (eff.mode == deser_ctl_pkg::MODE_FILT_ON);

  always_comb begin
    status           = '0;
    status.lock      = locked;
    status.sleep     = (state_reg == deser_ctl_pkg::ST_SLEEP);
    status.filter_on = filter_on;
    status.mode      = eff.mode;
    status.equalizer = eff.equalizer;
    status.override  = override;
  end

  // ---------------------------------------------------------------
  // apb read path
  // ---------------------------------------------------------------
  assign mapped = (paddr_i == deser_ctl_pkg::ADDR_OVERRIDE)
                | (paddr_i == deser_ctl_pkg::ADDR_CONFIG)
                | (paddr_i == deser_ctl_pkg::ADDR_STATUS);
  assign pready_o = 1'b1;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata_o  <= 32'h0;
      pslverr_o <= 1'b0;
    end else if (psel_i && !penable_i) begin
      pslverr_o <= ~mapped;
      case (paddr_i)
        deser_ctl_pkg::ADDR_OVERRIDE: prdata_o <= {24'h0, override_reg};
        deser_ctl_pkg::ADDR_CONFIG:   prdata_o <= 32'(cfg_reg);
        deser_ctl_pkg::ADDR_STATUS:   prdata_o <= 32'(status);
        default:                      prdata_o <= 32'h0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // stream watch and lock
  // ---------------------------------------------------------------
  assign stopped = (idle_reg >= 8'(STOP_CYCLES - 1));
  assign locked  = (state_reg == deser_ctl_pkg::ST_LOCKED);

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      idle_reg <= 8'h0;
    end else if (step) begin
      idle_reg <= 8'h0;
    end else if (!stopped) begin
      idle_reg <= idle_reg + 8'h1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg    <= deser_ctl_pkg::ST_OFF;
      lock_cnt_reg <= 8'h0;
    end else if (!pwr_reg) begin
      state_reg    <= deser_ctl_pkg::ST_OFF;
      lock_cnt_reg <= 8'h0;
    end else begin
      case (state_reg)
        deser_ctl_pkg::ST_OFF: begin
          state_reg    <= deser_ctl_pkg::ST_ACQUIRE;
          lock_cnt_reg <= 8'h0;
        end
        deser_ctl_pkg::ST_ACQUIRE: begin
          if (stopped) begin
            state_reg <= deser_ctl_pkg::ST_SLEEP;
          end else if (step && !frame_ok) begin
            lock_cnt_reg <= 8'h0;
          end else if (step && lock_cnt_reg >= 8'(LOCK_PIXELS - 1)) begin
            state_reg <= deser_ctl_pkg::ST_LOCKED;
          end else if (step) begin
            lock_cnt_reg <= lock_cnt_reg + 8'h1;
          end
        end
        deser_ctl_pkg::ST_LOCKED: begin
          if (stopped) begin
            state_reg <= deser_ctl_pkg::ST_SLEEP;
          end else if (step && !frame_ok) begin
            state_reg    <= deser_ctl_pkg::ST_ACQUIRE;
            lock_cnt_reg <= 8'h0;
          end
        end
        deser_ctl_pkg::ST_SLEEP: begin
          if (step) begin
            state_reg    <= deser_ctl_pkg::ST_ACQUIRE;
            lock_cnt_reg <= 8'h0;
          end
        end
        default: state_reg <= deser_ctl_pkg::ST_OFF;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // control filters and lane mapping
  // ---------------------------------------------------------------
  ctl_glitch_filter u_data_en (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .step_i    (step),
    .bypass_i  (~filter_on),
    .level_i   (pix_sync_reg.data_en),
    .level_o   (data_en_f)
  );
  ctl_glitch_filter u_hsync (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .step_i    (step),
    .bypass_i  (~filter_on),
    .level_i   (pix_sync_reg.hsync),
    .level_o   (hsync_f)
  );
  ctl_glitch_filter u_vsync (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .step_i    (step),
    .bypass_i  (~filter_on),
    .level_i   (pix_sync_reg.vsync),
    .level_o   (vsync_f)
  );

  function automatic logic [7:0] split(input logic [7:0] c, input logic msb);
    split = msb ? {c[7:6], c[5:0]} : {c[1:0], c[7:2]};
  endfunction

  assign map_r = split(pix_reg.r, eff.map_msb);
  assign map_g = split(pix_reg.g, eff.map_msb);
  assign map_b = split(pix_reg.b, eff.map_msb);

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lane_reg <= '0;
    end else if (step && locked) begin
      lane_reg[0] <= {map_g[0], map_r[5:0]};
      lane_reg[1] <= {map_b[1:0], map_g[5:1]};
      lane_reg[2] <= {data_en_f, vsync_f, hsync_f, map_b[5:2]};
      lane_reg[3] <= {1'b0, map_b[7:6], map_g[7:6], map_r[7:6]};
    end
  end

  // ---------------------------------------------------------------
  // oscillator and clock source switch
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      osc_cnt_reg <= 4'h0;
      osc_reg     <= 1'b0;
    end else if (osc_cnt_reg >= 4'(OSC_HALF - 1)) begin
      osc_cnt_reg <= 4'h0;
      osc_reg     <= ~osc_reg;
    end else begin
      osc_cnt_reg <= osc_cnt_reg + 4'h1;
    end
  end

  assign src_rec = locked;
  assign new_lvl = src_rec ? lclk_reg[2] : osc_reg;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      src_reg     <= 1'b0;
      hold_reg    <= 1'b0;
      clk_lvl_reg <= 1'b0;
    end else begin
      src_reg <= src_rec;
      if (src_rec != src_reg) begin
        hold_reg <= 1'b1;
      end else if (new_lvl == clk_lvl_reg) begin
        hold_reg <= 1'b0;
      end
      if (!hold_reg && src_rec == src_reg) begin
        clk_lvl_reg <= new_lvl;
      end
    end
  end

  // ---------------------------------------------------------------
  // output state matrix
  // ---------------------------------------------------------------
  always_comb begin
    drive_low = 1'b0;
    clk_drv   = 1'b0;
    lane_drv  = 1'b0;
    pass_drv  = 1'b0;
    if (!pwr_reg) begin
      pass_drv = 1'b0;
    end else if (locked) begin
      clk_drv  = strap_reg.out_en;
      lane_drv = strap_reg.out_en;
      pass_drv = 1'b1;
    end else if (!eff.oss) begin
      drive_low = 1'b1;
      clk_drv   = 1'b1;
      lane_drv  = 1'b1;
      pass_drv  = 1'b1;
    end else if (strap_reg.out_en) begin
      clk_drv = cfg_reg.osc_out;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lane_out_o       <= '0;
      lane_out_oe_n_o  <= 1'b1;
      clock_out_o      <= 1'b0;
      clock_out_oe_n_o <= 1'b1;
      pass_o           <= 1'b0;
      pass_oe_n_o      <= 1'b1;
      lock_o           <= 1'b0;
      low_power_o      <= 1'b1;
      equalizer_on_o   <= 1'b0;
    end else begin
      lane_out_o       <= drive_low ? '0 : lane_reg;
      lane_out_oe_n_o  <= ~lane_drv;
      clock_out_o      <= drive_low ? 1'b0 : clk_lvl_reg;
      clock_out_oe_n_o <= ~clk_drv;
      pass_o           <= ~drive_low;
      pass_oe_n_o      <= ~pass_drv;
      lock_o           <= locked;
      low_power_o      <= (state_reg == deser_ctl_pkg::ST_OFF)
                        | (state_reg == deser_ctl_pkg::ST_SLEEP);
      equalizer_on_o   <= eff.equalizer & pwr_reg;
    end
  end

endmodule

//--- tb/deser_ctl_props.sv
// Purpose: port assertions for the receiver control block
// Assumes: strap oss held high, config oss written high
// Notes:   bound into deser_mode_output_control
`timescale 1ns/1ns
module deser_ctl_props #(
  parameter int STOP_CYCLES = deser_ctl_pkg::STOP_CYCLES
) (
  // clock and reset
  input wire logic                   clk_sys_i,
  input wire logic                   rst_b_i,
  // pins
  input wire deser_ctl_pkg::straps_s straps_i,
  input wire logic                   power_down_n_i,
  input wire logic                   link_clk_i,
  // outputs
  input wire logic                   lane_out_oe_n_o,
  input wire logic                   clock_out_oe_n_o,
  input wire logic                   pass_o,
  input wire logic                   pass_oe_n_o,
  input wire logic                   lock_o,
  input wire logic                   low_power_o,
  input wire logic                   equalizer_on_o
);
  // ----
  // cycles since the last link clock edge
  // ----
  logic       link_q;
  logic [7:0] idle_cnt;
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      link_q   <= 1'b0;
      idle_cnt <= 8'h00;
    end else begin
      link_q <= link_clk_i;
      if (link_clk_i != link_q) idle_cnt <= 8'h00;
      else if (idle_cnt != 8'hff) idle_cnt <= idle_cnt + 8'h01;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  AST_PDN_OFF: assert property (
    (!power_down_n_i)[*6] |-> lane_out_oe_n_o && clock_out_oe_n_o && pass_oe_n_o)
    else $error("outputs driven in power down");
  AST_PDN_IDLE: assert property (
    (!power_down_n_i)[*6] |-> !lock_o && low_power_o && !equalizer_on_o)
    else $error("lock or equalizer on in power down");
  AST_PWRUP_NO_LOCK: assert property (
    $rose(power_down_n_i) |-> (!lock_o)[*8])
    else $error("lock at power up");
  AST_LOCK_PDN: assert property (
    $rose(lock_o) |-> $past(power_down_n_i, 8))
    else $error("lock without power");
  AST_LOCK_ACTIVE: assert property (
    (lock_o && straps_i.out_en && power_down_n_i)[*6] |->
      !lane_out_oe_n_o && !clock_out_oe_n_o && !pass_oe_n_o)
    else $error("outputs off while locked");
  AST_LOCK_OEN_LOW: assert property (
    (lock_o && !straps_i.out_en && power_down_n_i)[*6] |->
      lane_out_oe_n_o && clock_out_oe_n_o && !pass_oe_n_o && pass_o)
    else $error("wrong outputs with enable low");
  AST_UNLOCK_OSS: assert property (
    (power_down_n_i && !lock_o && straps_i.out_en && straps_i.oss)[*6] |->
      lane_out_oe_n_o && pass_oe_n_o)
    else $error("lanes driven while unlocked");
  AST_STOP_SLEEP: assert property (
    idle_cnt == 8'(STOP_CYCLES + 8) |-> !lock_o && low_power_o)
    else $error("no sleep on stopped stream");
  AST_LOCK_AWAKE: assert property (
    lock_o |-> !low_power_o)
    else $error("low power while locked");
  COV_LOCK: cover property ($rose(lock_o));
  COV_SLEEP: cover property (power_down_n_i && low_power_o && !lock_o);
  COV_OEN_LOW: cover property (lock_o && !straps_i.out_en);
endmodule

bind deser_mode_output_control deser_ctl_props #(.STOP_CYCLES(STOP_CYCLES)) props_i (
  .clk_sys_i, .rst_b_i, .straps_i, .power_down_n_i, .link_clk_i, .lane_out_oe_n_o,
  .clock_out_oe_n_o, .pass_o, .pass_oe_n_o, .lock_o, .low_power_o, .equalizer_on_o);

//--- tb/video_src_model.sv
// Purpose: upstream serializer model driving the recovered link
// Assumes: 400 ns pixel period while running
// Notes:   link clock stands still low while stopped
`timescale 1ns/1ns
module video_src_model (
  // control from the bench
  input  wire logic             run_i,
  input  wire logic             bad_i,
  input  wire logic [2:0]       ctl_i,
  input  wire logic [23:0]      rgb_i,
  // link
  output logic                  link_clk_o,
  output deser_ctl_pkg::pixel_s pixel_o
);
  initial begin
    link_clk_o = 1'b0;
    pixel_o = '0;
    forever begin
      if (run_i === 1'b1) begin
        #200 link_clk_o = 1'b1;
        #200 link_clk_o = 1'b0;
        pixel_o = {~bad_i, bad_i, ctl_i, rgb_i};
      end else begin
        #50;
      end
    end
  end
endmodule

//--- tb/tb_deser_mode_output_control.sv
// Purpose: self-checking bench for the receiver control block
// Assumes: serializer model on the link, apb master in tasks
// Notes:   short lock and stop counts keep the run brief
`timescale 1ns/1ns
module tb_deser_mode_output_control;
  // ----
  // signals
  // ----
  logic                   clk_sys_i, rst_b_i, psel_i, penable_i, pwrite_i, power_down_n_i;
  logic                   pready_o, pslverr_o, link_clk_i, clock_out_o, clock_out_oe_n_o;
  logic                   lane_out_oe_n_o, pass_o, pass_oe_n_o, lock_o, low_power_o;
  logic                   equalizer_on_o, run, bad, data_en_q, ck_q;
  logic [7:0]             paddr_i;
  logic [31:0]            pwdata_i, prdata_o;
  logic [2:0]             ctl;
  logic [23:0]            rgb;
  logic [32:0]            exp_q[$];
  deser_ctl_pkg::straps_s straps_i;
  deser_ctl_pkg::pixel_s  pixel_i;
  deser_ctl_pkg::lanes_t  lane_out_o;
  int                     errors, num_checks, seed, tog, ck, t0;
  int                     fm[6] = '{0, 1, 1, 1, 2, 3};
  int                     fw[6] = '{1, 1, 2, 3, 0, 0};
  int                     fn[6] = '{2, 0, 0, 2, 0, 0};

  deser_mode_output_control #(.LOCK_PIXELS(4), .STOP_CYCLES(24)) deser_mode_output_control_i (
    .clk_sys_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .straps_i, .power_down_n_i, .link_clk_i, .pixel_i, .lane_out_o,
    .lane_out_oe_n_o, .clock_out_o, .clock_out_oe_n_o, .pass_o, .pass_oe_n_o, .lock_o,
    .low_power_o, .equalizer_on_o);
  video_src_model video_src_model_i (.run_i(run), .bad_i(bad), .ctl_i(ctl), .rgb_i(rgb),
    .link_clk_o(link_clk_i), .pixel_o(pixel_i));

  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  // ----
  // tasks
  // ----
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    @(posedge clk_sys_i);
    while (pready_o !== 1'b1) @(posedge clk_sys_i);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wait_lock(input logic v);
    int n = 0;
    while (lock_o !== v && n < 3000) begin
      @(posedge clk_sys_i);
      n++;
    end
    chk(33'(lock_o), 33'(v));
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [32:0] st(input logic o, e, input logic [1:0] m, input logic f, s, l);
    st = {26'h0, o, e, m, f, s, l};
  endfunction
  function automatic deser_ctl_pkg::lanes_t lanes(input logic m, input logic [23:0] c);
    logic [5:0] r6, g6, b6;
    logic [1:0] r2, g2, b2;
    {r6, r2} = m ? {c[21:16], c[23:22]} : c[23:16];
    {g6, g2} = m ? {c[13:8], c[15:14]} : c[15:8];
    {b6, b2} = m ? {c[5:0], c[7:6]} : c[7:0];
    lanes = {1'b0, b2, g2, r2, 3'h0, b6[5:2], b6[1:0], g6[5:1], g6[0], r6};
  endfunction

  // watcher: read results and output toggles
  always @(posedge clk_sys_i) begin
    if (lane_out_o[2][6] !== data_en_q) tog++;
    if (clock_out_o !== ck_q) ck++;
    data_en_q <= lane_out_o[2][6];
    ck_q <= clock_out_o;
    if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i)
      chk({pslverr_o, prdata_o}, exp_q.pop_front());
  end

  initial begin
    #1000000;
    errors++;
    $display("unexpected at %0t: timeout", $time);
    final_report;
  end

  // ----
  // tests
  // ----
  initial begin
    seed = 33;
    rst_b_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    straps_i = 6'h38;
    power_down_n_i = 1'b1;
    run = 1'b1;
    bad = 1'b0;
    ctl = 3'h0;
    rgb = 24'h0;
    repeat (6) @(posedge clk_sys_i);
    chk(33'({lock_o, low_power_o, lane_out_oe_n_o, clock_out_oe_n_o, pass_oe_n_o}), 33'h0f);
    rst_b_i <= 1'b1;
    rd(deser_ctl_pkg::ADDR_OVERRIDE, 33'h0);
    rd(deser_ctl_pkg::ADDR_CONFIG, 33'h0);
    rd(8'h0c, 33'h100000000);
    $display("test registers done");
    for (int k = 0; k < 2; k++) begin
      rgb <= 24'($random(seed));
      straps_i.map_msb <= k[0];
      straps_i.equalizer <= k[0];
      wait_lock(1'b1);
      repeat (40) @(posedge clk_sys_i);
      chk(33'(lane_out_o), 33'(lanes(k[0], rgb)));
      chk(33'(equalizer_on_o), 33'(k[0]));
    end
    $display("test mapping done");
    for (int i = 0; i < 6; i++) begin
      straps_i.mode <= fm[i][1:0];
      repeat (10) @(posedge clk_sys_i);
      rd(deser_ctl_pkg::ADDR_STATUS, st(1'b0, 1'b1, fm[i][1:0], fm[i] == 1, 1'b0, 1'b1));
      t0 = tog;
      if (fw[i] > 0) begin
        ctl <= 3'h4;
        repeat (fw[i] * 8) @(posedge clk_sys_i);
      end
      ctl <= 3'h0;
      repeat (1120) @(posedge clk_sys_i);
      chk(33'(tog - t0), 33'(fn[i]));
    end
    $display("test modes done");
    straps_i.mode <= 2'h0;
    apb(1'b1, deser_ctl_pkg::ADDR_CONFIG, 32'h32);
    rd(deser_ctl_pkg::ADDR_STATUS, st(1'b0, 1'b1, 2'h0, 1'b0, 1'b0, 1'b1));
    apb(1'b1, deser_ctl_pkg::ADDR_OVERRIDE, 32'h1);
    rd(deser_ctl_pkg::ADDR_STATUS, st(1'b1, 1'b0, 2'h2, 1'b0, 1'b0, 1'b1));
    chk(33'(equalizer_on_o), 33'h0);
    $display("test override done");
    straps_i.out_en <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
    chk(33'({lane_out_oe_n_o, clock_out_oe_n_o, pass_oe_n_o, pass_o}), 33'hd);
    straps_i.out_en <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    chk(33'({lane_out_oe_n_o, clock_out_oe_n_o, pass_oe_n_o, pass_o}), 33'h1);
    $display("test enable done");
    run <= 1'b0;
    repeat (60) @(posedge clk_sys_i);
    chk(33'({lock_o, low_power_o}), 33'h1);
    rd(deser_ctl_pkg::ADDR_CONFIG, 33'h32);
    run <= 1'b1;
    wait_lock(1'b1);
    $display("test stop done");
    bad <= 1'b1;
    wait_lock(1'b0);
    repeat (10) @(posedge clk_sys_i);
    t0 = ck;
    chk(33'({lane_out_oe_n_o, clock_out_oe_n_o, pass_oe_n_o}), 33'h5);
    repeat (40) @(posedge clk_sys_i);
    chk(33'(ck - t0 > 4), 33'h1);
    bad <= 1'b0;
    wait_lock(1'b1);
    $display("test clock loss done");
    power_down_n_i <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
    chk(33'({lane_out_oe_n_o, clock_out_oe_n_o, pass_oe_n_o, lock_o, low_power_o}), 33'h1d);
    power_down_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    chk(33'(lock_o), 33'h0);
    rd(deser_ctl_pkg::ADDR_OVERRIDE, 33'h0);
    rd(deser_ctl_pkg::ADDR_CONFIG, 33'h0);
    wait_lock(1'b1);
    $display("test power down done");
    final_report;
  end
endmodule
